// file: shared/lpic_defines.svh
`ifndef LPIC_DEFINES_SVH
`define LPIC_DEFINES_SVH
// ==========================================================================
// Register offsets.
`define LPIC_ADDR_PERSIST 8'h0C
`define LPIC_ADDR_WAITCFG 8'h0D
`define LPIC_ADDR_PULSE 8'h0E
`define LPIC_ADDR_DRIVE 8'h0F
`define LPIC_ADDR_IDENT 8'h12
// ==========================================================================
// Field positions and values.
`define LPIC_PERS_NEAR_HI 7
`define LPIC_PERS_NEAR_LO 4
`define LPIC_PERS_CLR_HI 3
`define LPIC_PERS_CLR_LO 0
`define LPIC_WAIT_STRETCH_BIT 1
`define LPIC_DRIVE_HI 7
`define LPIC_DRIVE_LO 6
`define LPIC_GAIN_HI 1
`define LPIC_GAIN_LO 0
`define LPIC_RESET_VALUE 8'h00
`define LPIC_WAIT_STRETCH 4'hC
`define LPIC_CLR_DIRECT_MAX 4'h3
`define LPIC_CLR_STEP 6'h05
`define LPIC_CLR_BASE 4'h3
`define LPIC_CLR_DIRECT_RUN 6'h03
`define LPIC_CLR_TOP_CODE 4'hF
`define LPIC_CLR_TOP_RUN 6'h3C
// Arbitrary neutral part code.
`define LPIC_PART_CODE 8'hA5
`endif

// file: shared/lpic_pkg.sv
// ==========================================================================
// Types shared by the register bank.
package lpic_pkg;
  // Register access port: one write or read per strobe.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpic_req_t;
  // One finished measurement cycle of a channel.
  typedef struct packed {
    logic done;
    logic [15:0] value;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
  } lpic_result_t;
  // Settings forwarded to the analog block.
  typedef struct packed {
    logic [1:0] led_sink_strength;
    logic [1:0] colour_gain_select;
    logic [7:0] led_pulse_count;
    logic [11:0] wait_units;
  } lpic_analog_t;
endpackage

// file: design/lpic_regs.sv
`include "lpic_defines.svh"
module lpic_regs
  import lpic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lpic_req_t i_req,
  input wire logic [7:0] i_wait_period_count,
  input wire logic i_near_irq_permit,
  input wire logic i_clear_irq_permit,
  input wire lpic_result_t i_near,
  input wire lpic_result_t i_clear,
  output logic [7:0] o_rdata,
  output lpic_analog_t o_analog,
  output logic o_near_irq,
  output logic o_clear_irq,
  output logic o_irq
);
  logic [7:0] interrupt_persistence;
  logic [7:0] wait_scale_config;
  logic [7:0] led_pulse_count;
  logic [7:0] analog_drive_gain;
  logic [5:0] near_count;
  logic [5:0] clear_count;
  logic near_out;
  logic clear_out;
  logic [5:0] near_need;
  logic [5:0] clear_need;
  logic [5:0] next_near_count;
  logic [5:0] next_clear_count;

  // Out-of-range test shared by both channels.
  function automatic logic out_of_range(input lpic_result_t r);
    return (r.value < r.low_thr) || (r.value > r.high_thr);
  endfunction

  // Saturating increment of a run counter.
  function automatic logic [5:0] bump(input logic [5:0] c);
    return (c == 6'h3F) ? c : c + 6'h01;
  endfunction

  // ==========================================================================
  // Register writes; unused bits are stored as written.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      interrupt_persistence <= `LPIC_RESET_VALUE;
      wait_scale_config <= `LPIC_RESET_VALUE;
      led_pulse_count <= `LPIC_RESET_VALUE;
      analog_drive_gain <= `LPIC_RESET_VALUE;
    end else if (i_req.wr) begin
      case (i_req.addr)
        `LPIC_ADDR_PERSIST: interrupt_persistence <= i_req.wdata;
        `LPIC_ADDR_WAITCFG: wait_scale_config <= i_req.wdata;
        `LPIC_ADDR_PULSE: led_pulse_count <= i_req.wdata;
        `LPIC_ADDR_DRIVE: analog_drive_gain <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Read data, registered; unmapped addresses read zero.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `LPIC_RESET_VALUE;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `LPIC_ADDR_PERSIST: o_rdata <= interrupt_persistence;
        `LPIC_ADDR_WAITCFG: o_rdata <= wait_scale_config;
        `LPIC_ADDR_PULSE: o_rdata <= led_pulse_count;
        `LPIC_ADDR_DRIVE: o_rdata <= analog_drive_gain;
        `LPIC_ADDR_IDENT: o_rdata <= `LPIC_PART_CODE;
        default: o_rdata <= `LPIC_RESET_VALUE;
      endcase
    end
  end

  // ==========================================================================
  // Analog settings, registered each clock from the registers; wait units come from the wait period count input.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_analog <= '0;
    end else begin
      // drive code 00..11 is 100, 50, 25, 12.5 mA.
      o_analog.led_sink_strength <= analog_drive_gain[`LPIC_DRIVE_HI:`LPIC_DRIVE_LO];
      // gain code 00..11 is 1x, 4x, 16x, 60x.
      o_analog.colour_gain_select <= analog_drive_gain[`LPIC_GAIN_HI:`LPIC_GAIN_LO];
      o_analog.led_pulse_count <= led_pulse_count;
      // stretched wait counts twelve units per step.
      // units of the base wait period.
      o_analog.wait_units <= wait_scale_config[`LPIC_WAIT_STRETCH_BIT]
        ? 12'(({4'h0, i_wait_period_count}) * 12'(`LPIC_WAIT_STRETCH))
        : {4'h0, i_wait_period_count};
    end
  end

  // ==========================================================================
  // Required run lengths per channel.
  always_comb begin
    near_need = {2'b00, interrupt_persistence[`LPIC_PERS_NEAR_HI:`LPIC_PERS_NEAR_LO]};
    if (interrupt_persistence[`LPIC_PERS_CLR_HI:`LPIC_PERS_CLR_LO] <= `LPIC_CLR_DIRECT_MAX) begin
      clear_need = {2'b00, interrupt_persistence[`LPIC_PERS_CLR_HI:`LPIC_PERS_CLR_LO]};
    end else begin
      clear_need = 6'((interrupt_persistence[`LPIC_PERS_CLR_HI:`LPIC_PERS_CLR_LO] - `LPIC_CLR_BASE)
                   * `LPIC_CLR_STEP);
    end
  end

  // Next run counts.
  always_comb begin
    near_out = out_of_range(i_near);
    clear_out = out_of_range(i_clear);
    next_near_count = near_count;
    next_clear_count = clear_count;
    if (i_near.done) begin
      next_near_count = near_out ? bump(near_count) : 6'h00;
    end
    if (i_clear.done) begin
      next_clear_count = clear_out ? bump(clear_count) : 6'h00;
    end
  end

  // ==========================================================================
  // separate counters per channel.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      near_count <= 6'h00;
      clear_count <= 6'h00;
    end else begin
      near_count <= next_near_count;
      clear_count <= next_clear_count;
    end
  end

  // Qualified interrupts are sticky until the permit bit drops.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_near_irq <= 1'b0;
      o_clear_irq <= 1'b0;
    end else begin
      if (i_near_irq_permit && i_near.done &&
          (near_need == 6'h00 || next_near_count >= near_need)) begin
        o_near_irq <= 1'b1;
      end else if (!i_near_irq_permit) begin
        o_near_irq <= 1'b0;
      end
      if (i_clear_irq_permit && i_clear.done &&
          (clear_need == 6'h00 || next_clear_count >= clear_need)) begin
        o_clear_irq <= 1'b1;
      end else if (!i_clear_irq_permit) begin
        o_clear_irq <= 1'b0;
      end
    end
  end

  // Combined interrupt output.
  assign o_irq = o_near_irq | o_clear_irq;

  // ==========================================================================
  // Checks.
  // Near channel qualifies an interrupt on this result.
  sequence near_fire_s;
    i_near_irq_permit && i_near.done && (near_need == 6'h00 || next_near_count >= near_need);
  endsequence

  // Clear channel qualifies an interrupt on this result.
  sequence clear_fire_s;
    i_clear_irq_permit && i_clear.done && (clear_need == 6'h00 || next_clear_count >= clear_need);
  endsequence

  // A finished near result that lies within its thresholds.
  sequence near_in_range_s;
    i_near.done && (i_near.value >= i_near.low_thr) && (i_near.value <= i_near.high_thr);
  endsequence

  chk_near_every_cycle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_near_irq_permit && i_near.done && near_need == 6'h00) |=> o_near_irq)
    else $error("Near interrupt missing with zero persistence.");

  chk_near_fire: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    near_fire_s |=> o_near_irq)
    else $error("Near interrupt missing after run.");

  chk_near_quiet: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_near.done && !near_out && near_need != 6'h00 && !o_near_irq) |=> !o_near_irq)
    else $error("Near interrupt raised on an in-range result.");

  chk_clear_every_cycle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_clear_irq_permit && i_clear.done && clear_need == 6'h00) |=> o_clear_irq)
    else $error("Clear interrupt missing with zero persistence.");

  chk_clear_fire: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    clear_fire_s |=> o_clear_irq)
    else $error("Clear interrupt missing after run.");

  chk_clear_need_max: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (interrupt_persistence[`LPIC_PERS_CLR_HI:`LPIC_PERS_CLR_LO] == `LPIC_CLR_TOP_CODE) |-> (clear_need == `LPIC_CLR_TOP_RUN))
    else $error("Clear run length wrong for top code.");

  chk_clear_need_small: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (interrupt_persistence[`LPIC_PERS_CLR_HI:`LPIC_PERS_CLR_LO] == `LPIC_CLR_DIRECT_MAX) |-> (clear_need == `LPIC_CLR_DIRECT_RUN))
    else $error("Clear run length wrong for code three.");

  chk_near_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_near.done |=> (near_count == $past(near_count)))
    else $error("Near run moved without a near result.");

  chk_clear_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_clear.done |=> (clear_count == $past(clear_count)))
    else $error("Clear run moved without a clear result.");

  chk_ident_fixed: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.rd && i_req.addr == `LPIC_ADDR_IDENT) |=> (o_rdata == `LPIC_PART_CODE))
    else $error("Identification read wrong.");

  chk_near_in_range: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    near_in_range_s |=> (near_count == 6'h00))
    else $error("Near run kept on an in-range result.");

  chk_permit_gate: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_near_irq_permit |=> !o_near_irq)
    else $error("Near interrupt without permit.");

  chk_clear_gate: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_clear_irq_permit |=> !o_clear_irq)
    else $error("Clear interrupt without permit.");

  chk_run_reset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_clear.done && !clear_out) |=> (clear_count == 6'h00))
    else $error("Clear run not cleared on in-range result.");

  chk_wait_stretch: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wait_scale_config[`LPIC_WAIT_STRETCH_BIT] |=> (o_analog.wait_units == 12'($past(i_wait_period_count)) * 12'(`LPIC_WAIT_STRETCH)))
    else $error("Stretched wait units wrong.");

  chk_wait_plain: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !wait_scale_config[`LPIC_WAIT_STRETCH_BIT] |=> (o_analog.wait_units == {4'h0, $past(i_wait_period_count)}))
    else $error("Plain wait units wrong.");

  chk_pulse_fwd: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_analog.led_pulse_count == $past(led_pulse_count)))
    else $error("Pulse count not forwarded.");

  chk_drive_fwd: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_analog.led_sink_strength == $past(analog_drive_gain[`LPIC_DRIVE_HI:`LPIC_DRIVE_LO])))
    else $error("Drive code not forwarded.");

  chk_gain_fwd: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_analog.colour_gain_select == $past(analog_drive_gain[`LPIC_GAIN_HI:`LPIC_GAIN_LO])))
    else $error("Gain code not forwarded.");
endmodule

// file: bench/lpic_host_model.sv
`include "lpic_defines.svh"
// ==========================================================================
// Host side register access over the request strobe port.
module lpic_host_model
  import lpic_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output lpic_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // The port is idle from time zero.
  initial o_req = '0;
  // Writes one byte after an edge, then releases the strobe with junk data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = d;
    if (a == `LPIC_ADDR_WAITCFG) m = d & 8'h02;
    if (a == `LPIC_ADDR_DRIVE) m = d & 8'hC3;
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: m};
    @(posedge i_clk) #1;
    o_req.wr = 1'b0;
    o_req.wdata = ~m;
  endtask
  // Reads one byte; the data is taken once the strobe edge has passed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk) #1;
    o_req.rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// file: bench/light_prox_interrupt_config_tb_top.sv
`include "lpic_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
// ==========================================================================
// Self-checking bench for the register bank.
module light_prox_interrupt_config_tb_top
  import lpic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, np, cp;
  logic [7:0] wt, rdata, d;
  lpic_req_t req;
  lpic_result_t nr, cr;
  lpic_analog_t an;
  logic nirq, cirq, irq;
  int failures = 0;
  int check_count = 0;
  lpic_host_model host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
  lpic_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_wait_period_count(wt),
    .i_near_irq_permit(np), .i_clear_irq_permit(cp), .i_near(nr), .i_clear(cr),
    .o_rdata(rdata), .o_analog(an), .o_near_irq(nirq), .o_clear_irq(cirq), .o_irq(irq));
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Presents one finished result; low threshold 100, high threshold 200.
  task automatic res(input bit ch, input logic [15:0] v);
    @(posedge clk) #1;
    if (ch) cr = '{1'b1, v, 16'h0064, 16'h00C8};
    else nr = '{1'b1, v, 16'h0064, 16'h00C8};
    @(posedge clk) #1;
    nr.done = 1'b0;
    cr.done = 1'b0;
  endtask
  // Reset values, identification and unmapped space.
  task automatic t_regs();
    for (int a = 12; a < 16; a++) begin
      host.rd(8'(a), d);
      `CHK(d, 8'h00)
    end
    host.wr(8'h12, 8'h5A);
    host.rd(8'h12, d);
    `CHK(d, `LPIC_PART_CODE)
    host.rd(8'h10, d);
    `CHK(d, 8'h00)
    $display("test regs done");
  endtask
  // Drive and gain codes and the pulse count reach the analog block.
  task automatic t_analog();
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h0F, {2'(k), 4'hF, 2'(k)});
      host.wr(8'h0E, 8'(8'h5A + k));
      @(posedge clk) #1;
      `CHK(an.led_sink_strength, 2'(k))
      `CHK(an.colour_gain_select, 2'(k))
      `CHK(an.led_pulse_count, 8'(8'h5A + k))
    end
    host.rd(8'h0F, d);
    `CHK(d, 8'hC3)
    $display("test analog done");
  endtask
  // Wait units with and without the stretch bit.
  task automatic t_wait();
    host.wr(8'h0D, 8'hFF);
    @(posedge clk) #1;
    `CHK(an.wait_units, 12'h0084)
    host.wr(8'h0D, 8'h00);
    @(posedge clk) #1;
    `CHK(an.wait_units, 12'h000B)
    $display("test wait done");
  endtask
  // Near code three with a broken run, clear code zero.
  task automatic t_near();
    np = 1'b1;
    cp = 1'b1;
    host.wr(8'h0C, 8'h30);
    res(0, 16'h0032);
    res(0, 16'h0190);
    res(0, 16'h0096);
    `CHK(nirq, 1'b0)
    res(0, 16'h0032);
    res(0, 16'h0190);
    `CHK(nirq, 1'b0)
    res(0, 16'h0032);
    `CHK(nirq, 1'b1)
    `CHK(cirq, 1'b0)
    res(1, 16'h0096);
    `CHK(cirq, 1'b1)
    np = 1'b0;
    cp = 1'b0;
    @(posedge clk) #1;
    `CHK(irq, 1'b0)
    $display("test near done");
  endtask
  // Clear code four needs five, near code zero, gating by permit.
  task automatic t_clear();
    np = 1'b1;
    cp = 1'b1;
    host.wr(8'h0C, 8'h04);
    repeat (4) res(1, 16'h0032);
    `CHK(cirq, 1'b0)
    res(1, 16'h0032);
    `CHK(cirq, 1'b1)
    res(0, 16'h0096);
    `CHK(nirq, 1'b1)
    cp = 1'b0;
    res(1, 16'h0032);
    `CHK(cirq, 1'b0)
    `CHK(irq, 1'b1)
    $display("test clear done");
  endtask
  // Top clear code needs sixty, code three needs three; threshold values count as in range.
  task automatic t_codes();
    cp = 1'b0;
    host.wr(`LPIC_ADDR_PERSIST, 8'h0F);
    host.rd(`LPIC_ADDR_PERSIST, d);
    `CHK(d, 8'h0F)
    res(1, 16'h0096);
    cp = 1'b1;
    repeat (59) res(1, 16'h0032);
    `CHK(cirq, 1'b0)
    res(1, 16'h0032);
    `CHK(cirq, 1'b1)
    cp = 1'b0;
    host.wr(`LPIC_ADDR_PERSIST, 8'h03);
    cp = 1'b1;
    res(1, 16'h0064);
    res(1, 16'h00C8);
    res(1, 16'h0063);
    res(1, 16'h00C9);
    `CHK(cirq, 1'b0)
    res(1, 16'h0063);
    `CHK(cirq, 1'b1)
    $display("test codes done");
  endtask
  // A reset in mid-run clears registers, interrupts and the run count.
  task automatic t_reset();
    np = 1'b1;
    cp = 1'b0;
    host.wr(`LPIC_ADDR_PERSIST, 8'h20);
    res(0, 16'h0032);
    @(posedge clk) #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK(nirq, 1'b0)
    host.rd(`LPIC_ADDR_PERSIST, d);
    `CHK(d, 8'h00)
    host.wr(`LPIC_ADDR_PERSIST, 8'h20);
    res(0, 16'h0032);
    `CHK(nirq, 1'b0)
    res(0, 16'h0032);
    `CHK(nirq, 1'b1)
    $display("test reset done");
  endtask
  // Watchdog sized well beyond the expected run.
  initial begin
    #200000;
    failures++;
    close_out();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    np = 1'b0;
    cp = 1'b0;
    wt = 8'h0B;
    nr = '0;
    cr = '0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_analog();
    t_wait();
    t_near();
    t_clear();
    t_codes();
    t_reset();
    close_out();
  end
endmodule
